// ===== icu_pkg.sv
// Purpose: shared constants for the interrupt control/status slice
// Assumes: 16-bit register port, word offsets
// Notes:   offsets are word indices on the plain register port
package icu_pkg;
  localparam int unsigned DATA_W            = 16;
  localparam int unsigned ADDR_W            = 6;
  localparam logic [5:0]  OFS_PENDING_FIVE  = 6'h16;
  localparam logic [5:0]  OFS_CONTROL       = 6'h1D;
  localparam logic [5:0]  OFS_EVT_STATUS    = 6'h20;
  localparam logic [5:0]  OFS_EVT_MASK      = 6'h21;
  // control register fields
  localparam int unsigned BIT_INT_ACTIVE    = 15;
  localparam int unsigned BIT_PRIO_HI       = 14;
  localparam int unsigned BIT_PRIO_LO       = 13;
  localparam int unsigned BIT_VEC_HI        = 12;
  localparam int unsigned BIT_VEC_LO        = 6;
  localparam int unsigned BIT_GLOBAL_BLOCK  = 5;
  localparam int unsigned BIT_RSVD_ONE      = 4;
  localparam int unsigned BIT_PIN_LEVEL     = 2;
  localparam int unsigned BIT_EDGE_SELECT   = 0;
  // pending bank five: bit 0 holds vector 81, the rest read one
  localparam int unsigned BIT_PEND_81       = 0;
  localparam logic [15:0] PEND5_RSVD_ONES   = 16'hFFFE;
  // reset values
  localparam logic [1:0]  RST_PRIO          = 2'h0;
  localparam logic [6:0]  RST_VEC           = 7'h00;
  localparam logic        RST_BLOCK         = 1'b0;
  localparam logic        RST_EDGE          = 1'b0;
  localparam logic [3:0]  RST_EVT           = 4'h0;
  // event bits
  localparam int unsigned EVT_TAKEN         = 0;
  localparam int unsigned EVT_EXT_REQ       = 1;
  localparam int unsigned EVT_PEND81        = 2;
  localparam int unsigned EVT_BLOCKED       = 3;
  localparam int unsigned EVT_W             = 4;
  // reset vector is held until this many edges after release
  localparam int unsigned RST_VEC_HOLD_EDGES = 2;
  typedef enum logic [2:0] {
    RV_HOLD  = 3'b001,
    RV_WAIT  = 3'b010,
    RV_DONE  = 3'b100
  } icu_rv_state_t;
endpackage : icu_pkg

// ===== icu_ext_sense.sv
// Purpose: external request pin sensing, level or falling edge
// Assumes: pin is synchronous to clk, active low
// Notes:   low-power mode forces level sensing
`timescale 1ns/10ps
module icu_ext_sense (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_n,
  input  wire logic edge_sel,
  input  wire logic low_power,
  input  wire logic ack,
  output logic      req_q
);
  logic pin_prev_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_n;
    end
  end

  // edge mode latches the fall until the core takes it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q <= 1'b0;
    end else if (!edge_sel || low_power) begin
      req_q <= ~pin_n;
    end else if (pin_prev_q && !pin_n) begin
      req_q <= 1'b1;
    end else if (ack) begin
      req_q <= 1'b0;
    end
  end
endmodule : icu_ext_sense

// ===== icu_ctrl.sv
// Purpose: control/status slice of the interrupt controller unit
// Assumes: register reads return data one cycle after the strobe
// Notes:   request/priority/vector arrive from the arbitration logic
//
// What this block does
// - pending bit for vector 81 reads 0 while pending and 1 otherwise.
// - the upper bits of pending bank five read one and ignore writes.
// - control bit 15 shows whether a request is driven to the core.
// - bits 14-13 capture the new priority level when the core enters a routine.
// - the captured priority encodes the lowest level still allowed to nest.
// - bits 12-6 capture vector address bits 7-1 when the core enters a routine.
// - control bit 5 set blocks every interrupt to the core; reset clears it.
// - control bit 4 reads one and ignores writes.
// - control bit 2 shows the level of the external request pin.
// - control bit 0 picks low-level (0) or falling-edge (1) pin sensing.
// - in stop or wait mode the pin is level sensed regardless of bit 0.
// - the reset vector is driven during reset and until the second edge after release.
// - after reset every register is at its default, block bit 5 clear, so peripheral sources reach the core.
`timescale 1ns/10ps
module icu_ctrl #(
  parameter int unsigned VEC_W = 7
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata_q,
  input  wire logic        ext_request_pin_n,
  input  wire logic        low_power_mode,
  input  wire logic        vec81_request,
  input  wire logic        arb_request,
  input  wire logic [1:0]  arb_priority,
  input  wire logic [6:0]  arb_vector,
  input  wire logic        core_ack,
  output logic             core_irq_q,
  output logic             ext_request_q,
  output logic             reset_vector_sel_q,
  output logic             irq_out_q
);
  if (VEC_W != 7) begin : g_vec_w_check
    $error("icu_ctrl: VEC_W must be 7");
  end

  logic [1:0]       taken_priority_level_q;
  logic [6:0]       taken_vector_number_q;
  logic             global_request_block_q;
  logic             ext_request_edge_select_q;
  logic             pin_level_q;
  logic             pend81_n_q;
  logic [3:0]       evt_status_q;
  logic [3:0]       evt_mask_q;
  logic [3:0]       evt_set;
  logic             ext_req;
  logic             irq_drive;
  icu_pkg::icu_rv_state_t rv_state_q;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  icu_ext_sense u_sense (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pin_n     (ext_request_pin_n),
    .edge_sel  (ext_request_edge_select_q),
    .low_power (low_power_mode),
    .ack       (core_ack),
    .req_q     (ext_req)
  );

  // block gates both peripheral sources and the external pin
  assign irq_drive = (arb_request || ext_req) && !global_request_block_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_irq_q    <= 1'b0;
      ext_request_q <= 1'b0;
      pin_level_q   <= 1'b1;
      pend81_n_q    <= 1'b1;
    end else begin
      core_irq_q    <= irq_drive;
      ext_request_q <= ext_req && !global_request_block_q;
      pin_level_q   <= ext_request_pin_n;
      pend81_n_q    <= ~vec81_request;
    end
  end

  // captured fields move only on acknowledge, as one unit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_priority_level_q <= icu_pkg::RST_PRIO;
      taken_vector_number_q  <= icu_pkg::RST_VEC;
    end else if (core_ack) begin
      taken_priority_level_q <= arb_priority;
      taken_vector_number_q  <= arb_vector;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_request_block_q    <= icu_pkg::RST_BLOCK;
      ext_request_edge_select_q <= icu_pkg::RST_EDGE;
    end else if (reg_wr && hit(reg_addr, icu_pkg::OFS_CONTROL)) begin
      global_request_block_q    <= reg_wdata[icu_pkg::BIT_GLOBAL_BLOCK];
      ext_request_edge_select_q <= reg_wdata[icu_pkg::BIT_EDGE_SELECT];
    end
  end

  // reset vector select held until the second edge after release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rv_state_q         <= icu_pkg::RV_HOLD;
      reset_vector_sel_q <= 1'b1;
    end else begin
      case (rv_state_q)
        icu_pkg::RV_HOLD: begin
          rv_state_q         <= icu_pkg::RV_WAIT;
          reset_vector_sel_q <= 1'b1;
        end
        icu_pkg::RV_WAIT: begin
          rv_state_q         <= icu_pkg::RV_DONE;
          reset_vector_sel_q <= 1'b0;
        end
        icu_pkg::RV_DONE: begin
          rv_state_q         <= icu_pkg::RV_DONE;
          reset_vector_sel_q <= 1'b0;
        end
        default: begin
          rv_state_q         <= icu_pkg::RV_DONE;
          reset_vector_sel_q <= 1'b0;
        end
      endcase
    end
  end

  // events: set beats write-one-to-clear
  always_comb begin
    evt_set = '0;
    evt_set[icu_pkg::EVT_TAKEN]   = core_ack;
    evt_set[icu_pkg::EVT_EXT_REQ] = ext_req;
    evt_set[icu_pkg::EVT_PEND81]  = vec81_request;
    evt_set[icu_pkg::EVT_BLOCKED] = (arb_request || ext_req) && global_request_block_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_status_q <= icu_pkg::RST_EVT;
    end else if (reg_wr && hit(reg_addr, icu_pkg::OFS_EVT_STATUS)) begin
      evt_status_q <= (evt_status_q & ~reg_wdata[3:0]) | evt_set;
    end else begin
      evt_status_q <= evt_status_q | evt_set;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_mask_q <= icu_pkg::RST_EVT;
    end else if (reg_wr && hit(reg_addr, icu_pkg::OFS_EVT_MASK)) begin
      evt_mask_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out_q <= 1'b0;
    end else begin
      irq_out_q <= |((evt_status_q | evt_set) & evt_mask_q);
    end
  end

  // read mux; unmapped addresses read zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        icu_pkg::OFS_CONTROL: begin
          reg_rdata_q <= {core_irq_q, taken_priority_level_q, taken_vector_number_q,
                          global_request_block_q, 1'b1, 1'b0, pin_level_q, 1'b0,
                          ext_request_edge_select_q};
        end
        icu_pkg::OFS_PENDING_FIVE: begin
          reg_rdata_q <= icu_pkg::PEND5_RSVD_ONES | {15'h0000, pend81_n_q};
        end
        icu_pkg::OFS_EVT_STATUS: begin
          reg_rdata_q <= {12'h000, evt_status_q};
        end
        icu_pkg::OFS_EVT_MASK: begin
          reg_rdata_q <= {12'h000, evt_mask_q};
        end
        default: begin
          reg_rdata_q <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  // assertions
  property p_int_active;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> core_irq_q == $past((arb_request || ext_req) && !global_request_block_q);
  endproperty
  a_int_active: assert property (p_int_active) else $error("int flag wrong");

  property p_block;
    @(posedge clk) disable iff (sys_rst) global_request_block_q |=> !core_irq_q;
  endproperty
  a_block: assert property (p_block) else $error("blocked irq reached core");

  property p_capture_hold;
    @(posedge clk) disable iff (sys_rst) !core_ack |=> $stable(taken_vector_number_q) && $stable(taken_priority_level_q);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("fields moved without ack");

  property p_capture_load;
    @(posedge clk) disable iff (sys_rst) core_ack |=> taken_vector_number_q == $past(arb_vector)
      && taken_priority_level_q == $past(arb_priority);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("fields not loaded together");

  sequence s_ctl_read;
    reg_rd && reg_addr == icu_pkg::OFS_CONTROL;
  endsequence
  property p_ctl_fixed;
    @(posedge clk) disable iff (sys_rst) s_ctl_read |=> reg_rdata_q[4] && !reg_rdata_q[3] && !reg_rdata_q[1];
  endproperty
  a_ctl_fixed: assert property (p_ctl_fixed) else $error("reserved control bits wrong");

  property p_pend5;
    @(posedge clk) disable iff (sys_rst) reg_rd && reg_addr == icu_pkg::OFS_PENDING_FIVE
      |=> reg_rdata_q[15:1] == 15'h7FFF && reg_rdata_q[0] == $past(pend81_n_q);
  endproperty
  a_pend5: assert property (p_pend5) else $error("pending bank five wrong");

  property p_pin_level;
    @(posedge clk) disable iff (sys_rst) s_ctl_read |=> reg_rdata_q[2] == $past(pin_level_q);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  property p_low_power_level;
    @(posedge clk) disable iff (sys_rst) low_power_mode |=> ext_req == !$past(ext_request_pin_n);
  endproperty
  a_low_power_level: assert property (p_low_power_level) else $error("not level sensed");

  sequence s_rv_hold;
    reset_vector_sel_q [*2];
  endsequence
  property p_rv_release;
    @(posedge clk) $fell(sys_rst) |-> s_rv_hold ##1 !reset_vector_sel_q;
  endproperty
  a_rv_release: assert property (p_rv_release) else $error("reset vector timing wrong");

  // first edge of reset may see unreset flops, so wait for a second sample
  property p_rv_in_reset;
    @(posedge clk) sys_rst && $past(sys_rst) |-> reset_vector_sel_q;
  endproperty
  a_rv_in_reset: assert property (p_rv_in_reset) else $error("reset vector not held in reset");

  property p_rst_defaults;
    @(posedge clk) sys_rst && $past(sys_rst) |-> !core_irq_q && !irq_out_q && !global_request_block_q
      && !ext_request_edge_select_q && !ext_request_q;
  endproperty
  a_rst_defaults: assert property (p_rst_defaults) else $error("register not at default in reset");

  property p_ctl_write;
    @(posedge clk) disable iff (sys_rst) reg_wr && reg_addr == icu_pkg::OFS_CONTROL
      |=> global_request_block_q == $past(reg_wdata[icu_pkg::BIT_GLOBAL_BLOCK])
      && ext_request_edge_select_q == $past(reg_wdata[icu_pkg::BIT_EDGE_SELECT]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write not taken");

  property p_ext_blocked;
    @(posedge clk) disable iff (sys_rst) global_request_block_q |=> !ext_request_q;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked) else $error("blocked pin request shown");

  property p_level_follow;
    @(posedge clk) disable iff (sys_rst) !ext_request_edge_select_q |=> ext_req == !$past(ext_request_pin_n);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level sensing wrong");

  property p_edge_latch;
    @(posedge clk) disable iff (sys_rst)
      ext_request_edge_select_q && !low_power_mode && $fell(ext_request_pin_n) |=> ext_req;
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("falling edge missed");

  property p_edge_hold;
    @(posedge clk) disable iff (sys_rst)
      ext_request_edge_select_q && !low_power_mode && ext_req && !core_ack |=> ext_req;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge request dropped before ack");

  // a set in the clearing cycle must survive
  property p_evt_sticky;
    @(posedge clk) disable iff (sys_rst) (|evt_set) |=> (evt_status_q & $past(evt_set)) == $past(evt_set);
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event lost");

  property p_irq_out_level;
    @(posedge clk) disable iff (sys_rst) (|(evt_status_q & evt_mask_q)) |=> irq_out_q;
  endproperty
  a_irq_out_level: assert property (p_irq_out_level) else $error("masked-in event gave no interrupt");
endmodule : icu_ctrl

// ===== icu_core_model.sv
// Purpose: behavioural core that takes interrupts from the controller
// Assumes: irq is registered on clk
// Notes:   one ack per request, then waits for irq to drop
`timescale 1ns/10ps
module icu_core_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       irq,
  input  wire logic [3:0] dly,
  output logic            ack
);
  initial ack = 1'b0;
  always begin
    @(posedge clk);
    if (sys_rst === 1'b0 && irq === 1'b1) begin
      repeat (dly) @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      // irq lags one cycle, so a second ack would come too early
      while (irq === 1'b1) @(posedge clk);
    end
  end
endmodule : icu_core_model

// ===== interrupt_control_status_tb.sv
// Purpose: self-checking bench for the control/status slice
// Assumes: read data stands only in the cycle after the strobe
// Notes:   reads queue their expectation, a monitor compares
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module interrupt_control_status_tb;
  logic        clk, sys_rst, reg_wr, reg_rd, pin_n, low_power, vec81, arb_req, core_ack, rd_seen;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, exp_v;
  logic [1:0]  arb_prio, ep;
  logic [6:0]  arb_vec, ev;
  logic [3:0]  dly;
  logic        core_irq_q, ext_request_q, reset_vector_sel_q, irq_out_q;
  logic [15:0] exp_q[$];
  int          error_cnt, compares, rnd;
  icu_ctrl icu_ctrl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ext_request_pin_n(pin_n),
    .low_power_mode(low_power), .vec81_request(vec81), .arb_request(arb_req), .arb_priority(arb_prio),
    .arb_vector(arb_vec), .core_ack(core_ack), .core_irq_q(core_irq_q), .ext_request_q(ext_request_q),
    .reset_vector_sel_q(reset_vector_sel_q), .irq_out_q(irq_out_q));
  icu_core_model icu_core_model_i (.clk(clk), .sys_rst(sys_rst), .irq(core_irq_q), .dly(dly), .ack(core_ack));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen === 1'b1) begin
    exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD;
    `CHK(reg_rdata_q, exp_v)
  end
  function automatic logic [15:0] ctl(logic i, logic [1:0] p, logic [6:0] v, logic b, logic pl, logic e);
    return {i, p, v, b, 1'b1, 1'b0, pl, 1'b0, e};
  endfunction : ctl
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] a, logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk); reg_rd <= 1'b0;
  endtask : rd
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : idle
  task automatic wait_ack();
    int k;
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      if (core_ack === 1'b1) break;
    end
    if (k == 64) begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge clk);
  endtask : wait_ack
  task automatic do_reset();
    @(posedge clk); sys_rst <= 1'b1;
    idle(12); `CHK(reset_vector_sel_q, 1'b1)
    @(posedge clk); sys_rst <= 1'b0;
    idle(1); `CHK(reset_vector_sel_q, 1'b1)
    idle(1); `CHK(reset_vector_sel_q, 1'b0)
  endtask : do_reset
  initial begin
    {sys_rst, reg_wr, reg_rd, low_power, vec81, arb_req} = 6'h20;
    {reg_addr, reg_wdata, arb_prio, arb_vec, dly} = '0;
    pin_n = 1'b1;
    error_cnt = 0;
    compares = 0;
    rnd = $urandom(54);
    do_reset();
    rd(icu_pkg::OFS_CONTROL, ctl(1'b0, 2'h0, 7'h00, 1'b0, 1'b1, 1'b0));
    rd(icu_pkg::OFS_PENDING_FIVE, 16'hFFFF);
    rd(6'h3F, 16'h0000);
    wr(icu_pkg::OFS_CONTROL, 16'hFFFF);
    rd(icu_pkg::OFS_CONTROL, ctl(1'b0, 2'h0, 7'h00, 1'b1, 1'b1, 1'b1));
    wr(icu_pkg::OFS_CONTROL, 16'h0000);
    vec81 <= 1'b1;
    wr(icu_pkg::OFS_PENDING_FIVE, 16'h0000);
    rd(icu_pkg::OFS_PENDING_FIVE, 16'hFFFE);
    vec81 <= 1'b0;
    idle(2);
    wr(icu_pkg::OFS_EVT_STATUS, 16'h000F);
    wr(icu_pkg::OFS_EVT_MASK, 16'h0001);
    rd(icu_pkg::OFS_EVT_MASK, 16'h0001);
    idle(2); `CHK(irq_out_q, 1'b0)
    // every nesting code, random vector and core latency
    for (int i = 0; i < 4; i++) begin
      ep = 2'(i);
      ev = 7'($urandom);
      @(posedge clk);
      dly <= 4'($urandom_range(5, 0));
      arb_prio <= ep; arb_vec <= ev; arb_req <= 1'b1;
      wait_ack();
      arb_req <= 1'b0;
      idle(3);
      rd(icu_pkg::OFS_CONTROL, ctl(1'b0, ep, ev, 1'b0, 1'b1, 1'b0));
    end
    idle(1); `CHK(irq_out_q, 1'b1)
    rd(icu_pkg::OFS_EVT_STATUS, 16'h0001);
    wr(icu_pkg::OFS_EVT_MASK, 16'h0000);
    idle(2); `CHK(irq_out_q, 1'b0)
    wr(icu_pkg::OFS_EVT_MASK, 16'h0001);
    wr(icu_pkg::OFS_EVT_STATUS, 16'h0001);
    idle(2); `CHK(irq_out_q, 1'b0)
    rd(icu_pkg::OFS_EVT_STATUS, 16'h0000);
    wr(icu_pkg::OFS_CONTROL, 16'h0020);
    arb_req <= 1'b1;
    idle(4); `CHK(core_irq_q, 1'b0)
    rd(icu_pkg::OFS_CONTROL, ctl(1'b0, ep, ev, 1'b1, 1'b1, 1'b0));
    wr(icu_pkg::OFS_CONTROL, 16'h0000);
    wait_ack();
    arb_req <= 1'b0;
    pin_n <= 1'b0;
    idle(3); `CHK(ext_request_q, 1'b1)
    rd(icu_pkg::OFS_CONTROL, ctl(1'b1, ep, ev, 1'b0, 1'b0, 1'b0));
    @(posedge clk); pin_n <= 1'b1;
    idle(3); `CHK(ext_request_q, 1'b0)
    dly <= 4'h8;
    wr(icu_pkg::OFS_CONTROL, 16'h0001);
    pin_n <= 1'b0;
    @(posedge clk); pin_n <= 1'b1;
    idle(2); `CHK(ext_request_q, 1'b1)
    wait_ack();
    idle(3); `CHK(ext_request_q, 1'b0)
    // edge mode would hold the request past the check, level mode drops it
    @(posedge clk); low_power <= 1'b1; pin_n <= 1'b0;
    idle(3); `CHK(ext_request_q, 1'b1)
    @(posedge clk); pin_n <= 1'b1;
    idle(2); `CHK(ext_request_q, 1'b0)
    @(posedge clk); low_power <= 1'b0;
    do_reset();
    rd(icu_pkg::OFS_CONTROL, ctl(1'b0, 2'h0, 7'h00, 1'b0, 1'b1, 1'b0));
    rd(icu_pkg::OFS_EVT_MASK, 16'h0000);
    idle(2);
    report_and_stop();
  end
endmodule : interrupt_control_status_tb
